// >>> inc/flash_cfg_pkg.sv
// constants for the flash boot and read configuration block
// assumes a 10 MHz system clock and an oversampled serial link
package flash_cfg_pkg;

  // ==========================================================
  // timing
  localparam int CLK_MHZ = 10;
  localparam int QUICK_BOOT_US = 100;
  localparam int FULL_POR_US = 500;
  // longest time, rounded down, kept strictly below the bound
  localparam int QUICK_CYC = QUICK_BOOT_US * CLK_MHZ - 1;
  localparam int FULL_POR_CYC = FULL_POR_US * CLK_MHZ;

  // ==========================================================
  // persistent configuration word layout
  localparam int NV_DUM_LSB = 12;
  localparam int NV_XIP_LSB = 9;
  localparam int NV_QUICK_BIT = 5;
  localparam int NV_HOLD_BIT = 4;
  localparam int NV_QUAD_BIT = 3;
  localparam int NV_DUAL_BIT = 2;
  localparam logic [2:0] NV_XIP_OFF = 3'h7;

  // ==========================================================
  // volatile read configuration layout
  localparam int VCR_DUM_LSB = 4;
  localparam int VCR_XIP_BIT = 3;
  localparam int VCR_RSV_W = 3;
  localparam logic [7:0] VCR_RESET = 8'hf8;
  localparam logic [3:0] DUMMY_CODE_LO = 4'h0;
  localparam logic [3:0] DUMMY_CODE_HI = 4'hf;
  localparam logic [3:0] DUMMY_DEFAULT = 4'hf;

  // ==========================================================
  // status bytes
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_LATCH_BIT = 1;
  localparam int FL_READY_BIT = 7;

  // ==========================================================
  // link framing
  localparam int ADDR_BITS = 24;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] ADDR_CNT = 5'h18;
  localparam logic [5:0] SYNC_RESET = 6'h10;

  // ==========================================================
  // instruction codes (values arbitrary)
  localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h16;
  localparam logic [7:0] OP_VCR_WRITE = 8'h21;
  localparam logic [7:0] OP_VCR_READ = 8'h22;
  localparam logic [7:0] OP_STATUS_READ = 8'h31;
  localparam logic [7:0] OP_FLAG_READ = 8'h32;
  localparam logic [7:0] OP_SINGLE_FAST = 8'h41;
  localparam logic [7:0] OP_DUAL_OUT = 8'h42;
  localparam logic [7:0] OP_DUAL_IO = 8'h43;
  localparam logic [7:0] OP_QUAD_OUT = 8'h44;
  localparam logic [7:0] OP_QUAD_IO = 8'h45;
  localparam logic [7:0] OP_OTP_READ = 8'h46;

  typedef enum logic [1:0] {PROTO_SINGLE, PROTO_DUAL, PROTO_QUAD} proto_t;

endpackage

// >>> design/link_sync.sv
// two-stage synchroniser for link pins
// assumes inputs asynchronous to clk; reset is synchronous
`timescale 1ns/1ps
`default_nettype none

module link_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RV = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins in, synchronised out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  // ==========================================================
  // stages
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] out_reg;
  logic [W-1:0] out_next;

  // first stage feeds only the second
  always_comb
  begin
    meta_next = din;
    out_next = meta_reg;
  end

  // registers take a constant under reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_reg <= RV;
      out_reg <= RV;
    end
    else
    begin
      meta_reg <= meta_next;
      out_reg <= out_next;
    end
  end

  assign dout = out_reg;

endmodule
`default_nettype wire

// >>> design/flash_cfg_core.sv
// boot options and volatile read configuration of a serial flash
// assumes persistentCfg is stable and on clk; the link pins are not
//
// Contract
// [RULE1] quick boot: reads accepted before 100us
// [RULE2] first latch-set then starts full power-on phase
// [RULE3] second phase: only status polls accepted
// [RULE4] default: 500us power-on, no later latency
// [RULE5] cleared hold bit ignores line-three hold
// [RULE6] quad bit zero: four-line protocol at power-on
// [RULE7] dual bit zero: two-line protocol at power-on
// [RULE8] both zero: four-line protocol wins
// [RULE9] volatile write replaces dummy and direct settings
// [RULE10] dummy codes 0 and 15 mean default
// [RULE11] dummy count applies to all fast reads
// [RULE12] bit three zero arms direct-address mode
// [RULE13] direct-address frames carry no instruction byte
// [RULE14] host picks enough dummy clocks for speed
// [RULE15] reserved low bits written and read zero
// [RULE16] power-on reloads volatile word from persistent
`timescale 1ns/1ps
`default_nettype none

module flash_cfg_core #(
  parameter int POR_CYC = flash_cfg_pkg::FULL_POR_CYC
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic rst_n,
  // persistent configuration word
  input wire logic [15:0] persistentCfg,
  // serial link pins
  input wire logic linkClk,
  input wire logic selN,
  input wire logic [3:0] ioIn,
  output logic io1Out,
  output logic io1OeN,
  // configuration state
  output flash_cfg_pkg::proto_t proto,
  output logic holdEnable,
  output logic [3:0] dummyClocks,
  output logic directArmed,
  output logic directActive,
  // power-on state
  output logic readReady,
  output logic modifyReady,
  output logic powerPhase2,
  // read start towards the array
  output logic readGo,
  output logic [23:0] readAddr,
  output logic cmdReject
);

  // ==========================================================
  // pin synchronisers
  logic [5:0] syncOut;
  logic sclkS;
  logic selS;
  logic [3:0] ioS;

  link_sync #(.W(6), .RV(flash_cfg_pkg::SYNC_RESET)) pinSync (
    .clk(clk),
    .rst_n(rst_n),
    .din({linkClk, selN, ioIn}),
    .dout(syncOut)
  );

  assign {sclkS, selS, ioS} = syncOut;

  // ==========================================================
  // link edge detection
  logic sclkPrev_reg;
  logic selPrev_reg;
  logic rise;
  logic fall;
  logic selFall;
  logic holdOn;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sclkPrev_reg <= 1'b0;
      selPrev_reg <= 1'b1;
    end
    else
    begin
      sclkPrev_reg <= sclkS;
      selPrev_reg <= selS;
    end
  end

  // hold freezes the frame; quad mode uses line three for data
  assign holdOn = holdEnable && proto != flash_cfg_pkg::PROTO_QUAD && !ioS[3]; // [RULE5]
  assign rise = sclkS && !sclkPrev_reg && !holdOn;
  assign fall = !sclkS && sclkPrev_reg && !holdOn;
  assign selFall = !selS && selPrev_reg;

  // ==========================================================
  // power-on sequencing
  typedef enum logic [2:0] {B_LOAD, B_WAIT, B_QUICK, B_PHASE2, B_READY} boot_t;
  boot_t boot_reg;
  boot_t boot_next;
  logic [15:0] porCnt_reg;
  logic [15:0] porCnt_next;
  flash_cfg_pkg::proto_t proto_reg;
  flash_cfg_pkg::proto_t proto_next;
  logic hold_reg;
  logic hold_next;
  logic quick_reg;
  logic quick_next;
  logic wlsStart_reg;

  // options latch once per power-on, so changes need a new power-up
  always_comb
  begin
    boot_next = boot_reg;
    porCnt_next = porCnt_reg + 16'h0001;
    proto_next = proto_reg;
    hold_next = hold_reg;
    quick_next = quick_reg;
    unique case (boot_reg)
      B_LOAD:
      begin
        quick_next = !persistentCfg[flash_cfg_pkg::NV_QUICK_BIT];
        hold_next = persistentCfg[flash_cfg_pkg::NV_HOLD_BIT]; // [RULE5]
        if (!persistentCfg[flash_cfg_pkg::NV_QUAD_BIT])
          proto_next = flash_cfg_pkg::PROTO_QUAD; // [RULE6] [RULE8]
        else if (!persistentCfg[flash_cfg_pkg::NV_DUAL_BIT])
          proto_next = flash_cfg_pkg::PROTO_DUAL; // [RULE7]
        else
          proto_next = flash_cfg_pkg::PROTO_SINGLE;
        // the load cycle is the first counted cycle of power-on
        porCnt_next = 16'h0001;
        boot_next = B_WAIT;
      end
      B_WAIT:
      begin
        if (quick_reg && porCnt_reg == 16'(flash_cfg_pkg::QUICK_CYC - 1))
          boot_next = B_QUICK; // [RULE1]
        else if (!quick_reg && porCnt_reg == 16'(POR_CYC - 1))
          boot_next = B_READY; // [RULE4]
      end
      B_QUICK:
      begin
        porCnt_next = 16'h0000;
        if (wlsStart_reg)
          boot_next = B_PHASE2; // [RULE2]
      end
      B_PHASE2:
      begin
        if (porCnt_reg == 16'(POR_CYC - 1))
          boot_next = B_READY;
      end
      B_READY:
      begin
        porCnt_next = porCnt_reg;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      boot_reg <= B_LOAD;
      porCnt_reg <= 16'h0000;
      proto_reg <= flash_cfg_pkg::PROTO_SINGLE;
      hold_reg <= 1'b1;
      quick_reg <= 1'b0;
    end
    else
    begin
      boot_reg <= boot_next;
      porCnt_reg <= porCnt_next;
      proto_reg <= proto_next;
      hold_reg <= hold_next;
      quick_reg <= quick_next;
    end
  end

  assign proto = proto_reg;
  assign holdEnable = hold_reg;
  assign readReady = boot_reg == B_QUICK || boot_reg == B_READY;
  assign modifyReady = boot_reg == B_READY;
  assign powerPhase2 = boot_reg == B_PHASE2;

  // ==========================================================
  // frame decoding and volatile configuration
  typedef enum logic [2:0] {F_IDLE, F_CMD, F_ADDR, F_DUMMY, F_DATA, F_WRITE, F_OUT, F_SKIP}
    frame_t;
  frame_t st_reg;
  frame_t st_next;
  logic [23:0] shift_reg;
  logic [23:0] shift_next;
  logic [4:0] bitCnt_reg;
  logic [4:0] bitCnt_next;
  logic [3:0] dumCnt_reg;
  logic [3:0] dumCnt_next;
  logic [7:0] outByte_reg;
  logic [7:0] outByte_next;
  logic outBit_reg;
  logic outBit_next;
  logic [7:0] vcr_reg;
  logic [7:0] vcr_next;
  logic latch_reg;
  logic latch_next;
  logic direct_reg;
  logic direct_next;
  logic [23:0] addr_reg;
  logic [23:0] addr_next;
  logic readGo_reg;
  logic readGo_next;
  logic reject_reg;
  logic reject_next;
  logic wlsStart_next;
  logic [23:0] shIn;
  logic [4:0] step;
  logic [4:0] bitInc;
  logic [7:0] cmd;
  logic isPoll;
  logic isFast;
  logic [7:0] statusByte;
  logic [7:0] flagByte;

  // lines per link clock follow the power-on protocol
  always_comb
  begin
    unique case (proto_reg)
      flash_cfg_pkg::PROTO_QUAD:
      begin
        step = 5'h04;
        shIn = {shift_reg[19:0], ioS};
      end
      flash_cfg_pkg::PROTO_DUAL:
      begin
        step = 5'h02;
        shIn = {shift_reg[21:0], ioS[1:0]};
      end
      default:
      begin
        step = 5'h01;
        shIn = {shift_reg[22:0], ioS[0]};
      end
    endcase
  end

  assign bitInc = bitCnt_reg + step;
  assign cmd = shIn[7:0];
  assign isPoll = cmd == flash_cfg_pkg::OP_STATUS_READ || cmd == flash_cfg_pkg::OP_FLAG_READ;
  // one dummy count serves every fast read and the otp read
  assign isFast = cmd inside {flash_cfg_pkg::OP_SINGLE_FAST, flash_cfg_pkg::OP_DUAL_OUT,
    flash_cfg_pkg::OP_DUAL_IO, flash_cfg_pkg::OP_QUAD_OUT, flash_cfg_pkg::OP_QUAD_IO,
    flash_cfg_pkg::OP_OTP_READ}; // [RULE11]

  // status bytes for polling
  always_comb
  begin
    statusByte = 8'h00;
    statusByte[flash_cfg_pkg::ST_BUSY_BIT] = powerPhase2;
    statusByte[flash_cfg_pkg::ST_LATCH_BIT] = latch_reg;
    flagByte = 8'h00;
    flagByte[flash_cfg_pkg::FL_READY_BIT] = modifyReady;
  end

  // next frame state
  always_comb
  begin
    st_next = st_reg;
    shift_next = shift_reg;
    bitCnt_next = bitCnt_reg;
    dumCnt_next = dumCnt_reg;
    outByte_next = outByte_reg;
    outBit_next = outBit_reg;
    vcr_next = vcr_reg;
    latch_next = latch_reg;
    direct_next = direct_reg;
    addr_next = addr_reg;
    readGo_next = 1'b0;
    reject_next = 1'b0;
    wlsStart_next = 1'b0;
    if (boot_reg == B_LOAD)
    begin
      // earlier volatile writes are lost at every power-on
      vcr_next = {persistentCfg[flash_cfg_pkg::NV_DUM_LSB +: 4],
        persistentCfg[flash_cfg_pkg::NV_XIP_LSB +: 3] == flash_cfg_pkg::NV_XIP_OFF,
        3'h0}; // [RULE16]
      latch_next = 1'b0;
      direct_next = 1'b0;
    end
    if (selS)
    begin
      st_next = F_IDLE;
      outBit_next = 1'b0;
    end
    else if (selFall)
    begin
      st_next = direct_reg ? F_ADDR : F_CMD; // [RULE13]
      bitCnt_next = 5'h00;
      shift_next = 24'h000000;
    end
    else if (rise)
    begin
      unique case (st_reg)
        F_CMD:
        begin
          shift_next = shIn;
          bitCnt_next = bitInc;
          if (bitInc >= flash_cfg_pkg::BYTE_BITS)
          begin
            bitCnt_next = 5'h00;
            st_next = F_SKIP;
            if (!readReady && !powerPhase2)
              reject_next = 1'b1;
            else if (isPoll)
            begin
              // polls stay open during the second phase
              st_next = F_OUT; // [RULE3]
              outByte_next = cmd == flash_cfg_pkg::OP_FLAG_READ ? flagByte : statusByte;
            end
            else if (powerPhase2)
              reject_next = 1'b1; // [RULE3]
            else if (isFast)
              st_next = F_ADDR;
            else if (cmd == flash_cfg_pkg::OP_WRITE_LATCH_SET)
            begin
              latch_next = 1'b1;
              wlsStart_next = boot_reg == B_QUICK; // [RULE2] [RULE4]
            end
            else if (cmd == flash_cfg_pkg::OP_VCR_WRITE)
            begin
              if (modifyReady && latch_reg)
                st_next = F_WRITE;
              else
                reject_next = 1'b1;
            end
            else if (cmd == flash_cfg_pkg::OP_VCR_READ)
            begin
              st_next = F_OUT;
              outByte_next = vcr_reg;
            end
          end
        end
        F_ADDR:
        begin
          shift_next = shIn;
          bitCnt_next = bitInc;
          if (bitInc >= flash_cfg_pkg::ADDR_CNT)
          begin
            addr_next = shIn;
            dumCnt_next = 4'h0;
            st_next = F_DUMMY;
          end
        end
        F_DUMMY:
        begin
          // line zero on the first dummy clock enters, keeps or leaves direct mode
          if (dumCnt_reg == 4'h0)
            direct_next = directArmed && !ioS[0]; // [RULE12]
          dumCnt_next = dumCnt_reg + 4'h1;
          if (dumCnt_next == dummyClocks)
          begin
            st_next = F_DATA; // [RULE11]
            readGo_next = 1'b1;
          end
        end
        F_WRITE:
        begin
          shift_next = shIn;
          bitCnt_next = bitInc;
          if (bitInc >= flash_cfg_pkg::BYTE_BITS)
          begin
            vcr_next = {shIn[7:flash_cfg_pkg::VCR_RSV_W], 3'h0}; // [RULE9] [RULE15]
            latch_next = 1'b0;
            st_next = F_SKIP;
          end
        end
        default:
        begin
        end
      endcase
    end
    else if (fall && st_reg == F_OUT)
    begin
      // byte repeats, so a poll may run for many bytes
      outBit_next = outByte_reg[7];
      outByte_next = {outByte_reg[6:0], outByte_reg[7]};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_reg <= F_IDLE;
      shift_reg <= 24'h000000;
      bitCnt_reg <= 5'h00;
      dumCnt_reg <= 4'h0;
      outByte_reg <= 8'h00;
      outBit_reg <= 1'b0;
      vcr_reg <= flash_cfg_pkg::VCR_RESET;
      latch_reg <= 1'b0;
      direct_reg <= 1'b0;
      addr_reg <= 24'h000000;
      readGo_reg <= 1'b0;
      reject_reg <= 1'b0;
      wlsStart_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      shift_reg <= shift_next;
      bitCnt_reg <= bitCnt_next;
      dumCnt_reg <= dumCnt_next;
      outByte_reg <= outByte_next;
      outBit_reg <= outBit_next;
      vcr_reg <= vcr_next;
      latch_reg <= latch_next;
      direct_reg <= direct_next;
      addr_reg <= addr_next;
      readGo_reg <= readGo_next;
      reject_reg <= reject_next;
      wlsStart_reg <= wlsStart_next;
    end
  end

  // codes 0 and 15 fall back to the full-speed count
  assign dummyClocks = (vcr_reg[7:4] == flash_cfg_pkg::DUMMY_CODE_LO ||
    vcr_reg[7:4] == flash_cfg_pkg::DUMMY_CODE_HI) ? flash_cfg_pkg::DUMMY_DEFAULT
    : vcr_reg[7:4]; // [RULE10]
  assign directArmed = !vcr_reg[flash_cfg_pkg::VCR_XIP_BIT]; // [RULE12]
  assign directActive = direct_reg;
  assign readGo = readGo_reg;
  assign readAddr = addr_reg;
  assign cmdReject = reject_reg;
  assign io1Out = outBit_reg;
  assign io1OeN = st_reg != F_OUT;

  // ==========================================================
  // checks
  chk_quad_priority: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
    $past(boot_reg) == B_LOAD && boot_reg == B_WAIT
    && !$past(persistentCfg[flash_cfg_pkg::NV_QUAD_BIT])
    |-> proto == flash_cfg_pkg::PROTO_QUAD)
    else $error("quad bit low did not select four lines");
  chk_dual_select: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
    $past(boot_reg) == B_LOAD && boot_reg == B_WAIT
    && $past(persistentCfg[flash_cfg_pkg::NV_QUAD_BIT])
    && !$past(persistentCfg[flash_cfg_pkg::NV_DUAL_BIT]) |-> proto == flash_cfg_pkg::PROTO_DUAL)
    else $error("dual bit low did not select two lines");
  chk_vcr_reload: assert property (@(posedge clk) disable iff (!rst_n) // [RULE16]
    $past(boot_reg) == B_LOAD && boot_reg == B_WAIT
    |-> vcr_reg[7:4] == $past(persistentCfg[15:12]))
    else $error("volatile dummy not reloaded at power-on");
  chk_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n) // [RULE15]
    vcr_reg[2:0] == 3'h0)
    else $error("reserved volatile bits not zero");
  chk_quick_ready: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
    boot_reg == B_WAIT && quick_reg |-> ##[0:1000] readReady)
    else $error("quick boot too slow");
  chk_phase2_start: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
    wlsStart_reg |=> powerPhase2 [*8])
    else $error("latch set did not start second phase");
  chk_phase2_reject: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
    rise && st_reg == F_CMD && powerPhase2 && bitInc >= flash_cfg_pkg::BYTE_BITS && !isPoll
    |=> cmdReject && st_reg == F_SKIP)
    else $error("instruction accepted during second phase");
  chk_no_early_read: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
    readGo |-> $past(readReady) && $past(st_reg) == F_DUMMY)
    else $error("read started outside a ready dummy phase");
  chk_hold_gate: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
    holdOn && !selS && !selFall |=> $stable(bitCnt_reg) && $stable(shift_reg))
    else $error("link clock counted while held");

endmodule
`default_nettype wire

// >>> sim/flash_host_model.sv
// host model of the serial link: frames, line-zero shifting, read-back
// assumes a 100 ns clk; one link period is eight clk periods
`timescale 1ns/1ps
`default_nettype none

module flash_host_model (
  // system clock
  input wire logic clk,
  // link pins
  output logic linkClk,
  output logic selN,
  output logic [3:0] ioIn,
  input wire logic io1Out
);
  // ==========================================
  // idle pins: clock parked low, device deselected
  logic lastOut;
  // line three level for the next clocks; low asks for hold
  logic holdLine;
  initial
  begin
    linkClk = 1'b0;
    selN = 1'b1;
    ioIn = 4'hd;
    lastOut = 1'b0;
    holdLine = 1'b1;
  end

  // one link clock, entered on a falling clk edge; data set while low
  task automatic edge1(input logic d0);
    linkClk = 1'b0;
    ioIn = {holdLine, 1'b1, ~ioIn[1], d0}; // line one is the device's: keep it moving
    repeat (4) @(negedge clk);
    linkClk = 1'b1;
    repeat (2) @(negedge clk);
    lastOut = io1Out;
    repeat (2) @(negedge clk);
  endtask

  // shift n bits out on line zero, msb first
  task automatic send(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
      edge1(v[i]);
  endtask

  // collect one byte from line one, msb first
  task automatic recv(output logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      edge1(1'b0);
      b[i] = lastOut;
    end
  endtask

  // frame start: select first, clock still parked
  task automatic open_frame();
    @(negedge clk);
    selN = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  // frame end; released lines take a new level, not the old one
  task automatic close_frame();
    linkClk = 1'b0;
    repeat (4) @(negedge clk);
    selN = 1'b1;
    ioIn = ~ioIn;
    repeat (4) @(negedge clk);
  endtask
endmodule

`default_nettype wire

// >>> sim/tb_flash_boot_and_read_config.sv
// self-checking bench for the boot and read configuration block
// assumes the host model drives the link; clk 100 ns, link 800 ns
`timescale 1ns/1ps
`default_nettype none

module tb_flash_boot_and_read_config;
  // ==========================================
  // short power-on count keeps the run brief
  localparam int POR = 400;
  logic clk;
  logic rst_n;
  logic [15:0] persistentCfg;
  logic linkClk, selN, io1Out, io1OeN, holdEnable, directArmed, directActive;
  logic readReady, modifyReady, powerPhase2, readGo, cmdReject;
  logic [3:0] ioIn;
  logic [3:0] dummyClocks;
  logic [23:0] readAddr;
  flash_cfg_pkg::proto_t proto;
  int errors, nChecks, goCnt, rejCnt;

  // system clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  flash_cfg_core #(.POR_CYC(POR)) dut_u (.clk(clk), .rst_n(rst_n), .persistentCfg(persistentCfg),
    .linkClk(linkClk), .selN(selN), .ioIn(ioIn), .io1Out(io1Out), .io1OeN(io1OeN), .proto(proto),
    .holdEnable(holdEnable), .dummyClocks(dummyClocks), .directArmed(directArmed),
    .directActive(directActive), .readReady(readReady), .modifyReady(modifyReady),
    .powerPhase2(powerPhase2), .readGo(readGo), .readAddr(readAddr), .cmdReject(cmdReject));
  flash_host_model host_u (.clk(clk), .linkClk(linkClk), .selN(selN), .ioIn(ioIn),
    .io1Out(io1Out));

  // pulses last one cycle, so tally them for later judging
  always @(posedge clk)
  begin
    if (readGo === 1'b1)
      goCnt <= goCnt + 1;
    if (cmdReject === 1'b1)
      rejCnt <= rejCnt + 1;
  end

  // ==========================================
  // comparison and verdict
  task automatic cmp(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      errors++;
    end
  endtask

  task automatic end_sim();
    if (errors == 0 && nChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // power cycle; cyc counts clocks until reads are taken
  task automatic power_on(input logic [15:0] cfg, output int cyc);
    @(negedge clk);
    persistentCfg = cfg;
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    cyc = 0;
    while (readReady !== 1'b1 && cyc < 1500)
    begin
      @(negedge clk);
      cyc++;
    end
    if (cyc >= 1500)
    begin
      errors++;
      end_sim();
    end
  endtask

  // whole frame: code then n payload bits
  task automatic cmd(input logic [7:0] op, input logic [31:0] v, input int n);
    host_u.open_frame();
    host_u.send({24'h0, op}, 8);
    host_u.send(v, n);
    host_u.close_frame();
  endtask

  // volatile write always needs the latch set first
  task automatic wvol(input logic [7:0] v);
    cmd(flash_cfg_pkg::OP_WRITE_LATCH_SET, 32'h0, 0);
    cmd(flash_cfg_pkg::OP_VCR_WRITE, {24'h0, v}, 8);
  endtask

  task automatic rd(input logic [7:0] op, output logic [7:0] b);
    host_u.open_frame();
    host_u.send({24'h0, op}, 8);
    host_u.recv(b);
    cmp("line one driven", io1OeN, 1'b0);
    host_u.close_frame();
    cmp("line one released", io1OeN, 1'b1);
  endtask

  // ==========================================
  // scenarios
  task automatic t_protocols();
    int cyc;
    flash_cfg_pkg::proto_t ep [4] = '{flash_cfg_pkg::PROTO_QUAD, flash_cfg_pkg::PROTO_QUAD,
      flash_cfg_pkg::PROTO_DUAL, flash_cfg_pkg::PROTO_SINGLE};
    for (int i = 0; i < 4; i++)
    begin
      power_on({10'h3ff, 1'b1, (i != 0), i[1:0], 2'h3}, cyc);
      cmp("protocol", proto, ep[i]);
      cmp("hold", holdEnable, (i != 0));
    end
  endtask

  task automatic t_boot_vol();
    int cyc;
    logic [7:0] b;
    logic [3:0] code [4] = '{4'h0, 4'h1, 4'he, 4'hf};
    logic [3:0] exp [4] = '{4'hf, 4'h1, 4'he, 4'hf};
    power_on(16'h7fff, cyc);
    cmp("ready time", (cyc >= POR - 3 && cyc <= POR + 3), 1'b1);
    cmp("modify ready", modifyReady, 1'b1);
    rd(flash_cfg_pkg::OP_VCR_READ, b);
    cmp("volatile at power", b, 8'h78);
    wvol(8'h57); // reserved bits sent set on purpose
    cmp("no late phase", powerPhase2, 1'b0);
    cmp("dummy written", dummyClocks, 4'h5);
    cmp("direct armed", directArmed, 1'b1);
    rd(flash_cfg_pkg::OP_VCR_READ, b);
    cmp("volatile read", b, 8'h50);
    cmd(flash_cfg_pkg::OP_VCR_WRITE, 32'h38, 8);
    cmp("write w/o latch", dummyClocks, 4'h5);
    for (int i = 0; i < 4; i++)
    begin
      wvol({code[i], 4'h8});
      cmp("dummy code", dummyClocks, exp[i]);
    end
  endtask

  task automatic t_fast();
    int g;
    wvol(8'h38); // three dummy clocks, reserved bits zero
    for (int op = 'h41; op <= 'h46; op++)
    begin
      g = goCnt;
      host_u.open_frame();
      host_u.send(op, 8);
      host_u.holdLine = 1'b0;
      host_u.send(32'hf, 4); // clocks under hold are not counted
      host_u.holdLine = 1'b1;
      host_u.send(32'ha50000 + op, 24);
      host_u.send(32'h3, 2);
      repeat (3) @(negedge clk);
      cmp("early start", goCnt - g, 0);
      host_u.send(32'h1, 1);
      repeat (3) @(negedge clk);
      cmp("read start", goCnt - g, 1);
      cmp("read address", readAddr, 32'ha50000 + op);
      host_u.close_frame();
    end
  endtask

  task automatic t_direct();
    int g;
    wvol(8'h20); // two dummy clocks, direct mode armed
    cmd(flash_cfg_pkg::OP_SINGLE_FAST, 32'h12345600, 32); // line zero low on first dummy
    cmp("direct entered", directActive, 1'b1);
    g = goCnt;
    host_u.open_frame();
    host_u.send(32'h654321, 24); // no instruction byte
    host_u.send(32'h2, 2); // line zero high leaves the mode
    repeat (3) @(negedge clk);
    cmp("direct start", goCnt - g, 1);
    cmp("direct address", readAddr, 32'h654321);
    host_u.close_frame();
    cmp("direct left", directActive, 1'b0);
  endtask

  task automatic t_quick();
    int cyc;
    int r;
    int g;
    logic [7:0] b;
    power_on(16'h7fdf, cyc);
    cmp("quick ready", cyc <= flash_cfg_pkg::QUICK_CYC, 1'b1);
    cmp("not modify ready", modifyReady, 1'b0);
    cmp("reload", dummyClocks, 4'h7);
    r = rejCnt;
    g = goCnt;
    cmd(flash_cfg_pkg::OP_SINGLE_FAST, 32'h0, 31); // address and seven dummy clocks
    cmp("early read", rejCnt - r, 0);
    cmp("early read start", goCnt - g, 1);
    cmd(flash_cfg_pkg::OP_WRITE_LATCH_SET, 32'h0, 0);
    cmp("second phase", powerPhase2, 1'b1);
    cmd(flash_cfg_pkg::OP_VCR_WRITE, 32'h38, 8);
    cmp("refused in phase", rejCnt - r, 1);
    rd(flash_cfg_pkg::OP_STATUS_READ, b); // only polls meanwhile
    cmp("poll taken", rejCnt - r, 1);
    cmp("phase flag", b[0], 1'b1);
    cyc = 0;
    while (modifyReady !== 1'b1 && cyc < 2000)
    begin
      @(negedge clk);
      cyc++;
    end
    cmp("phase latency", (cyc > 0 && cyc < POR), 1'b1);
    cmp("phase over", powerPhase2, 1'b0);
    rd(flash_cfg_pkg::OP_FLAG_READ, b);
    cmp("flag ready", b[7], 1'b1);
    cmp("flag poll taken", rejCnt - r, 1);
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    persistentCfg = 16'hffff;
    errors = 0;
    nChecks = 0;
    goCnt = 0;
    rejCnt = 0;
    t_protocols();
    t_boot_vol();
    t_fast();
    t_direct();
    t_quick();
    end_sim();
  end
endmodule

`default_nettype wire
